// *** dual_channel_serial_output_port.sv ***
// Dual-channel serial output port: AHB-Lite register slave on CLK,
// serial shifter and bit clock generator on DEVICE_INPUT_CLOCK.
// Assumes both clocks free-running and unrelated; pins are split into
// value and output enable, the pad resolves the wire.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.

// Function
// [RQ1] Each channel word goes out in two's complement, MSB first, channel A and B on own lines.
// [RQ2] Data bits change on the rising bit clock edge for polarity 0 and the falling edge for 1.
// [RQ3] The receiver samples on the falling edge for polarity 0 and the rising edge for 1.
// [RQ4] Both data lines stay undriven after reset until the drive enable bit is set.
// [RQ5] The bit clock stays undriven after reset until the drive enable bit is set.
// [RQ6] In debug mode the bit clock keeps running so the debug bits on the data lines can be captured.
// [RQ7] With rate 0 the input clock itself is passed to the bit clock pin, keeping its duty cycle.
// [RQ8] Holding the master reset low returns every register, configuration included, to reset.
// [RQ9] A word strobe of programmable polarity pulses per word unpacked, or per I/Q pair packed.
// [RQ10] A nonzero rate divides the input clock, with data changes on the chosen update edge.
module dual_channel_serial_output_port (
  input  wire logic         CLK,
  input  wire logic         RESET_N,
  input  wire logic         DEVICE_INPUT_CLOCK,
  input  wire logic         HSEL,
  input  wire logic [31:0]  HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic         HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic         HREADY,
  output logic      [31:0]  HRDATA,
  output logic              HREADYOUT,
  output logic              HRESP,
  output logic              CHAN_A_SERIAL_OUT,
  output logic              CHAN_A_SERIAL_OE,
  output logic              CHAN_B_SERIAL_OUT,
  output logic              CHAN_B_SERIAL_OE,
  output logic              SERIAL_BIT_CLOCK,
  output logic              SERIAL_BIT_CLOCK_OE,
  output logic              SERIAL_WORD_STROBE,
  output logic              SERIAL_WORD_STROBE_OE
);

  // ---------------- Bus domain ----------------
  serial_port_pkg::cfg_t                      ctrl;
  logic [serial_port_pkg::RATE_W-1:0]         rate;
  logic [serial_port_pkg::WORD_W-1:0]         chan_a_word;
  logic [serial_port_pkg::WORD_W-1:0]         chan_b_word;
  logic [serial_port_pkg::DBG_W-1:0]          dbg;
  logic                                       overrun;
  logic                                       req_tgl;
  logic [1:0]                                 ack_sync;
  logic                                       wr_pend;
  logic [serial_port_pkg::ADDR_W-1:0]         wr_addr;
  logic                                       busy;
  logic                                       addr_ok;
  logic                                       commit;
  logic [serial_port_pkg::WORD_W-1:0]         next_rdata;

  assign addr_ok = HSEL && HREADY
                 && (HTRANS == serial_port_pkg::HTRANS_NONSEQ
                     || HTRANS == serial_port_pkg::HTRANS_SEQ);
  assign busy    = req_tgl != ack_sync[1];
  assign commit  = wr_pend && wr_addr == serial_port_pkg::CHAN_B_ADDR;

  // Zero wait state slave, always OKAY
  always_ff @(posedge CLK)
  begin
    HREADYOUT <= 1'b1;
    HRESP     <= 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else
    begin
      wr_pend <= addr_ok && HWRITE;
      wr_addr <= HADDR[serial_port_pkg::ADDR_W-1:0];
    end
  end

  always_comb
  begin
    next_rdata = '0;
    case (HADDR[serial_port_pkg::ADDR_W-1:0])
      serial_port_pkg::CTRL_ADDR:   next_rdata[serial_port_pkg::CTRL_W-1:0] = ctrl;
      serial_port_pkg::RATE_ADDR:   next_rdata[serial_port_pkg::RATE_W-1:0] = rate;
      serial_port_pkg::CHAN_A_ADDR: next_rdata = chan_a_word;
      serial_port_pkg::CHAN_B_ADDR: next_rdata = chan_b_word;
      serial_port_pkg::DEBUG_ADDR:  next_rdata[serial_port_pkg::DBG_W-1:0] = dbg;
      serial_port_pkg::STATUS_ADDR:
      begin
        next_rdata[serial_port_pkg::STAT_BUSY]    = busy;
        next_rdata[serial_port_pkg::STAT_OVERRUN] = overrun;
      end
      default:                      next_rdata = '0;
    endcase
  end

  // Read data is fetched during the address phase so no wait state is needed
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      HRDATA <= '0;
    else if (addr_ok && !HWRITE)
      HRDATA <= next_rdata;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ctrl <= serial_port_pkg::CFG_RESET;                                    // [RQ8]
      rate <= serial_port_pkg::RATE_RESET;                                   // [RQ8]
      dbg  <= '0;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        serial_port_pkg::CTRL_ADDR:  ctrl <= HWDATA[serial_port_pkg::CTRL_W-1:0];
        serial_port_pkg::RATE_ADDR:  rate <= HWDATA[serial_port_pkg::RATE_W-1:0];
        serial_port_pkg::DEBUG_ADDR: dbg  <= HWDATA[serial_port_pkg::DBG_W-1:0];
        default:                     ;
      endcase
    end
  end

  // Sample words are frozen while a pair is waiting for the link side
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      chan_a_word <= '0;
      chan_b_word <= '0;
    end
    else if (wr_pend && !busy)
    begin
      if (wr_addr == serial_port_pkg::CHAN_A_ADDR)
        chan_a_word <= HWDATA;
      if (wr_addr == serial_port_pkg::CHAN_B_ADDR)
        chan_b_word <= HWDATA;
    end
  end

  // Writing channel B hands the pair to the link; a channel A or B write while busy is an overrun
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      req_tgl <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      if (commit && !busy)
        req_tgl <= ~req_tgl;
      if (wr_pend && busy && (wr_addr == serial_port_pkg::CHAN_B_ADDR
                              || wr_addr == serial_port_pkg::CHAN_A_ADDR))
        overrun <= 1'b1;
      else if (wr_pend && wr_addr == serial_port_pkg::STATUS_ADDR
               && HWDATA[serial_port_pkg::STAT_OVERRUN])
        overrun <= 1'b0;
    end
  end

  // ---------------- Link domain ----------------
  logic [1:0]                                 rst_sync;
  logic                                       lrst_n;
  serial_port_pkg::link_cfg_t                 cfg_s1;
  serial_port_pkg::link_cfg_t                 cfg_s2;
  serial_port_pkg::link_cfg_t                 cfg_s3;
  serial_port_pkg::link_cfg_t                 lcfg;
  logic [2:0]                                 req_sync;
  logic                                       ack_tgl;
  logic                                       word_ready;
  logic [serial_port_pkg::WORD_W-1:0]         hold_a;
  logic [serial_port_pkg::WORD_W-1:0]         hold_b;
  logic [serial_port_pkg::WORD_W-1:0]         shift_a;
  logic [serial_port_pkg::WORD_W-1:0]         shift_b;
  logic [serial_port_pkg::BIT_CNT_W-1:0]      bit_cnt;
  logic [serial_port_pkg::RATE_W-1:0]         div_cnt;
  logic                                       raw_clk;
  logic                                       update;
  logic                                       load;
  logic                                       div_clk;

  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    rst_sync <= {rst_sync[0], RESET_N};
  end
  assign lrst_n = rst_sync[1];

  // Configuration is quasi-static; it is adopted only once two samples agree
  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    if (!lrst_n)
    begin
      cfg_s1 <= serial_port_pkg::LINK_CFG_RESET;
      cfg_s2 <= serial_port_pkg::LINK_CFG_RESET;
      cfg_s3 <= serial_port_pkg::LINK_CFG_RESET;
      lcfg   <= serial_port_pkg::LINK_CFG_RESET;                            // [RQ8]
    end
    else
    begin
      cfg_s1 <= '{cfg: ctrl, rate: rate, dbg: dbg};
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      // Only synchronised copies are compared; the bus-side word is never read here
      if (cfg_s2 == cfg_s3)
        lcfg <= cfg_s2;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      ack_sync <= '0;
    else
      ack_sync <= {ack_sync[0], ack_tgl};
  end

  // Bit clock divider: half period of rate+1 input clocks
  assign update = (lcfg.rate == '0) || (div_cnt == lcfg.rate && !raw_clk);  // [RQ10]

  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    if (!lrst_n)
    begin
      div_cnt <= '0;
      raw_clk <= 1'b0;
    end
    else if (lcfg.rate == '0)
    begin
      div_cnt <= '0;
      raw_clk <= 1'b0;
    end
    else if (div_cnt == lcfg.rate)
    begin
      div_cnt <= '0;
      raw_clk <= ~raw_clk;                                                   // [RQ10]
    end
    else
      div_cnt <= div_cnt + 1'b1;
  end

  // Pair hand-over from the bus side
  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    if (!lrst_n)
    begin
      req_sync   <= '0;
      ack_tgl    <= 1'b0;
      word_ready <= 1'b0;
      hold_a     <= '0;
      hold_b     <= '0;
    end
    else
    begin
      req_sync <= {req_sync[1:0], req_tgl};
      // Level compare with the ack, so a request arriving while a pair waits is kept
      if (req_sync[2] != ack_tgl && !word_ready)
      begin
        hold_a     <= chan_a_word;
        hold_b     <= chan_b_word;
        word_ready <= 1'b1;
        ack_tgl    <= ~ack_tgl;
      end
      else if (load)
        word_ready <= 1'b0;
    end
  end

  // A new pair follows the last bit with no gap
  assign load = update && word_ready && bit_cnt <= 6'd1;

  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    if (!lrst_n)
    begin
      shift_a <= '0;
      shift_b <= '0;
      bit_cnt <= '0;
    end
    else if (load)
    begin
      shift_a <= hold_a;                                                     // [RQ1]
      shift_b <= hold_b;                                                     // [RQ1]
      bit_cnt <= serial_port_pkg::FRAME_BITS;
    end
    else if (update && bit_cnt != '0)
    begin
      shift_a <= {shift_a[serial_port_pkg::WORD_W-2:0], 1'b0};              // [RQ1]
      shift_b <= {shift_b[serial_port_pkg::WORD_W-2:0], 1'b0};
      bit_cnt <= bit_cnt - 1'b1;
    end
  end

  // Pin stage; outside debug mode data moves only on the update edge of the bit clock
  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    if (!lrst_n)
    begin
      CHAN_A_SERIAL_OUT  <= 1'b0;
      CHAN_B_SERIAL_OUT  <= 1'b0;
      SERIAL_WORD_STROBE <= 1'b0;
    end
    else if (lcfg.cfg.debug_mode)
    begin
      CHAN_A_SERIAL_OUT  <= lcfg.dbg[serial_port_pkg::DBG_A];
      CHAN_B_SERIAL_OUT  <= lcfg.dbg[serial_port_pkg::DBG_B];
      SERIAL_WORD_STROBE <= lcfg.dbg[serial_port_pkg::DBG_STB];
    end
    else if (update)
    begin
      CHAN_A_SERIAL_OUT  <= load ? hold_a[serial_port_pkg::WORD_W-1]         // [RQ2]
                          : (bit_cnt > 6'd1 ? shift_a[serial_port_pkg::WORD_W-2] : 1'b0);
      CHAN_B_SERIAL_OUT  <= load ? hold_b[serial_port_pkg::WORD_W-1]         // [RQ2]
                          : (bit_cnt > 6'd1 ? shift_b[serial_port_pkg::WORD_W-2] : 1'b0);
      SERIAL_WORD_STROBE <= lcfg.cfg.strobe_polarity ^ (load || (!lcfg.cfg.packed_pair
                          && bit_cnt == serial_port_pkg::HALF_MARK + 1'b1));  // [RQ9]
    end
  end

  // Divided clock: raw rising edge is the update edge, polarity flips the pin
  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    if (!lrst_n)
      div_clk <= 1'b0;
    else if (lcfg.rate != '0 && div_cnt == lcfg.rate)
      div_clk <= ~raw_clk ^ lcfg.cfg.serial_clock_polarity;                 // [RQ2]
    else if (lcfg.rate != '0)
      div_clk <= raw_clk ^ lcfg.cfg.serial_clock_polarity;
    else
      div_clk <= lcfg.cfg.serial_clock_polarity;
  end

  // Rate 0 bypasses the flop so the input clock duty cycle reaches the pin;
  // the clock runs in debug mode as well
  assign SERIAL_BIT_CLOCK = (lcfg.rate == '0)                                // [RQ7] [RQ6]
                          ? DEVICE_INPUT_CLOCK ^ lcfg.cfg.serial_clock_polarity
                          : div_clk;

  always_ff @(posedge DEVICE_INPUT_CLOCK)
  begin
    if (!lrst_n)
    begin
      CHAN_A_SERIAL_OE      <= 1'b0;                                         // [RQ4]
      CHAN_B_SERIAL_OE      <= 1'b0;                                         // [RQ4]
      SERIAL_BIT_CLOCK_OE   <= 1'b0;                                         // [RQ5]
      SERIAL_WORD_STROBE_OE <= 1'b0;
    end
    else
    begin
      CHAN_A_SERIAL_OE      <= lcfg.cfg.serial_port_drive_enable;            // [RQ4]
      CHAN_B_SERIAL_OE      <= lcfg.cfg.serial_port_drive_enable;            // [RQ4]
      SERIAL_BIT_CLOCK_OE   <= lcfg.cfg.serial_port_drive_enable;            // [RQ5]
      SERIAL_WORD_STROBE_OE <= lcfg.cfg.serial_port_drive_enable;
    end
  end

endmodule : dual_channel_serial_output_port

// *** serial_port_pkg.sv ***
// Package for the dual-channel serial output port: register map,
// control field layout, reset values and the configuration carrier.
// Assumes one AHB-Lite master with 32-bit single word transfers.
package serial_port_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          WORD_W         = 32;
  localparam int          HALF_W         = 16;
  localparam int          RATE_W         = 8;
  localparam int          BIT_CNT_W      = 6;

  // Register byte addresses
  localparam logic [7:0]  CTRL_ADDR      = 8'h00;
  localparam logic [7:0]  RATE_ADDR      = 8'h04;
  localparam logic [7:0]  CHAN_A_ADDR    = 8'h08;
  localparam logic [7:0]  CHAN_B_ADDR    = 8'h0C;
  localparam logic [7:0]  DEBUG_ADDR     = 8'h10;
  localparam logic [7:0]  STATUS_ADDR    = 8'h14;

  // Control register fields
  localparam int          CTRL_ENABLE    = 0;
  localparam int          CTRL_CLK_POL   = 1;
  localparam int          CTRL_STB_POL   = 2;
  localparam int          CTRL_PACKED    = 3;
  localparam int          CTRL_DEBUG     = 4;
  localparam int          CTRL_W         = 5;

  // Status register fields
  localparam int          STAT_BUSY      = 0;
  localparam int          STAT_OVERRUN   = 1;

  // Debug register width: bit 2 strobe, bit 1 line A, bit 0 line B
  localparam int          DBG_W          = 3;
  localparam int          DBG_STB        = 2;
  localparam int          DBG_A          = 1;
  localparam int          DBG_B          = 0;

  localparam logic [BIT_CNT_W-1:0] FRAME_BITS = 6'd32;
  localparam logic [BIT_CNT_W-1:0] HALF_MARK  = 6'd16;
  localparam logic [RATE_W-1:0]    RATE_RESET = 8'h00;

  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ     = 2'b11;

  typedef struct packed {
    logic                 debug_mode;
    logic                 packed_pair;
    logic                 strobe_polarity;
    logic                 serial_clock_polarity;
    logic                 serial_port_drive_enable;
  } cfg_t;

  localparam cfg_t        CFG_RESET      = '0;

  typedef struct packed {
    cfg_t                 cfg;
    logic [RATE_W-1:0]    rate;
    logic [DBG_W-1:0]     dbg;
  } link_cfg_t;

  localparam link_cfg_t   LINK_CFG_RESET = '{cfg: CFG_RESET, rate: RATE_RESET, dbg: '0};

endpackage : serial_port_pkg

// *** dual_channel_serial_output_port_props.sv ***
// Pin-level checker for the dual-channel serial output port.
// Assumes the bind below and a bus master that keeps AHB-Lite rules.
module serial_port_props (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        DEVICE_INPUT_CLOCK,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        CHAN_A_SERIAL_OUT,
  input wire logic        CHAN_A_SERIAL_OE,
  input wire logic        CHAN_B_SERIAL_OUT,
  input wire logic        CHAN_B_SERIAL_OE,
  input wire logic        SERIAL_BIT_CLOCK_OE,
  input wire logic        SERIAL_WORD_STROBE,
  input wire logic        SERIAL_WORD_STROBE_OE
);
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic [4:0] ctrl_shadow;
  logic [4:0] off_cnt;
  wire        take = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      wr_pend <= 1'b0;
    else if (HREADY)
      wr_pend <= take && HWRITE;
    if (take)
      wr_addr <= HADDR[7:0];
  end
  // Shadow lands where the design stores it: at the end of the data phase
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      ctrl_shadow <= '0;
    else if (wr_pend && HREADY && wr_addr == serial_port_pkg::CTRL_ADDR)
      ctrl_shadow <= HWDATA[4:0];
  end
  always_ff @(posedge CLK)
  begin
    if (!RESET_N || ctrl_shadow[0])
      off_cnt <= '0;
    else if (off_cnt != 5'h1F)
      off_cnt <= off_cnt + 5'h01;
  end
  // No disable here: these look at the pins while reset is held
  AST_RESET_PINS: assert property (@(posedge CLK) !RESET_N [*8] |-> !CHAN_A_SERIAL_OE
    && !CHAN_B_SERIAL_OE && !SERIAL_BIT_CLOCK_OE && !SERIAL_WORD_STROBE_OE)
    else $error("drive enable high during reset");
  AST_RESET_LINES: assert property (@(posedge CLK) !RESET_N [*8] |-> !CHAN_A_SERIAL_OUT
    && !CHAN_B_SERIAL_OUT && !SERIAL_WORD_STROBE) else $error("serial lines not cleared");
  AST_RESET_BUS: assert property (@(posedge CLK) !RESET_N |=> HRDATA == 32'h0)
    else $error("read data not cleared by reset");
  AST_OE_DATA: assert property (@(posedge DEVICE_INPUT_CLOCK) disable iff (!RESET_N)
    CHAN_A_SERIAL_OE == CHAN_B_SERIAL_OE && CHAN_A_SERIAL_OE == SERIAL_BIT_CLOCK_OE)
    else $error("data and clock enables differ");
  AST_OE_STROBE: assert property (@(posedge DEVICE_INPUT_CLOCK) disable iff (!RESET_N)
    SERIAL_WORD_STROBE_OE == CHAN_A_SERIAL_OE) else $error("strobe enable differs");
  AST_CTRL_READ: assert property (@(posedge CLK) disable iff (!RESET_N)
    take && !HWRITE && HADDR[7:0] == serial_port_pkg::CTRL_ADDR
    |=> HRDATA[4:0] == $past(ctrl_shadow)) else $error("control readback wrong");
  AST_ENABLE_FOLLOW: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(ctrl_shadow[0]) |-> ##[1:20] (CHAN_A_SERIAL_OE && SERIAL_BIT_CLOCK_OE))
    else $error("pins not driven after enable");
  AST_DRIVE_GATED: assert property (@(posedge CLK) disable iff (!RESET_N)
    off_cnt == 5'h1F |-> !CHAN_A_SERIAL_OE && !CHAN_B_SERIAL_OE && !SERIAL_BIT_CLOCK_OE)
    else $error("pins driven while disabled");
endmodule : serial_port_props

bind dual_channel_serial_output_port serial_port_props serial_port_props_i (
  .CLK(CLK), .RESET_N(RESET_N), .DEVICE_INPUT_CLOCK(DEVICE_INPUT_CLOCK), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .CHAN_A_SERIAL_OUT(CHAN_A_SERIAL_OUT), .CHAN_A_SERIAL_OE(CHAN_A_SERIAL_OE),
  .CHAN_B_SERIAL_OUT(CHAN_B_SERIAL_OUT), .CHAN_B_SERIAL_OE(CHAN_B_SERIAL_OE),
  .SERIAL_BIT_CLOCK_OE(SERIAL_BIT_CLOCK_OE), .SERIAL_WORD_STROBE(SERIAL_WORD_STROBE),
  .SERIAL_WORD_STROBE_OE(SERIAL_WORD_STROBE_OE));

// *** serial_sink_model.sv ***
// Receiver model: captures one 32-bit word per line from the serial pins.
// Assumes resolved wires; an undriven line reads as z and never matches.
module serial_sink_model (
  input wire logic   bit_clock,
  input wire logic   data_a,
  input wire logic   data_b,
  input wire logic   strobe,
  input wire logic   clock_polarity,
  input wire logic   strobe_polarity,
  input wire logic   listen,
  output logic [31:0] word_a,
  output logic [31:0] word_b,
  output int          frames,
  output int          stb_hits
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] sh_a;
  logic [31:0] sh_b;
  int          count = 0;
  int          hits = 0;
  logic        active;
  initial frames = 0;
  // Sample edge: falling for polarity 0, rising for polarity 1
  always @(bit_clock)
  begin
    active = (strobe === ~strobe_polarity);
    if (bit_clock === clock_polarity)
    begin
      if (!listen)
        count = 0;
      else if (count != 0 || active)
      begin
        if (count == 0)
          hits = 0;
        sh_a = {sh_a[30:0], data_a};
        sh_b = {sh_b[30:0], data_b};
        hits = hits + int'(active);
        count++;
        if (count == 32)
        begin
          word_a = sh_a;
          word_b = sh_b;
          stb_hits = hits;
          frames++;
          count = 0;
        end
      end
    end
  end
endmodule : serial_sink_model

// *** tb.sv ***
// Testbench: AHB-Lite register access and serial capture by a receiver model.
// Assumes the bus slave answers with zero wait states but never relies on it.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, reset_n, lclk, hsel, hwrite, hreadyout, hresp, listen, m_pol, m_stb_pol;
  logic [31:0] haddr, hwdata, hrdata, word_a, word_b;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        a_out, a_oe, b_out, b_oe, sck, sck_oe, stb, stb_oe;
  int          frames, stb_hits, n_mismatch, n_compared;
  wire         a_wire = a_oe ? a_out : 1'bz;
  wire         b_wire = b_oe ? b_out : 1'bz;
  wire         sck_wire = sck_oe ? sck : 1'bz;
  wire         stb_wire = stb_oe ? stb : 1'bz;

  dual_channel_serial_output_port dual_channel_serial_output_port_i (
    .CLK(clk), .RESET_N(reset_n), .DEVICE_INPUT_CLOCK(lclk), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CHAN_A_SERIAL_OUT(a_out),
    .CHAN_A_SERIAL_OE(a_oe), .CHAN_B_SERIAL_OUT(b_out), .CHAN_B_SERIAL_OE(b_oe),
    .SERIAL_BIT_CLOCK(sck), .SERIAL_BIT_CLOCK_OE(sck_oe), .SERIAL_WORD_STROBE(stb),
    .SERIAL_WORD_STROBE_OE(stb_oe));
  serial_sink_model serial_sink_model_i (
    .bit_clock(sck_wire), .data_a(a_wire), .data_b(b_wire), .strobe(stb_wire),
    .clock_polarity(m_pol), .strobe_polarity(m_stb_pol), .listen(listen),
    .word_a(word_a), .word_b(word_b), .frames(frames), .stb_hits(stb_hits));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Link clock free-running, offset so its edges never meet the bus clock's
  initial
  begin
    lclk = 1'b0;
    #13;
    forever #40 lclk = ~lclk;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic step(inout int i, input int lim);
    i++;
    if (i > lim)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge clk);
  endtask : step

  task automatic wait_ready();
    int i = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      step(i, 50);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= serial_port_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check_word(what, exp, q);
  endtask : rd_chk

  task automatic send_pair(input logic [31:0] a, input logic [31:0] b, input int hits);
    int f = frames;
    int i = 0;
    listen = 1'b1;
    wr(serial_port_pkg::CHAN_A_ADDR, a);
    wr(serial_port_pkg::CHAN_B_ADDR, b);
    while (frames == f)
      step(i, 3000);
    check_word("line a word", a, word_a);
    check_word("line b word", b, word_b);
    check_word("strobe count", hits, stb_hits);
  endtask : send_pair

  task automatic check_clock(input logic pol);
    repeat (4)
    begin
      @(posedge lclk);
      #20;
      check_word("bit clock high phase", {31'h0, ~pol}, {31'h0, sck});
      #40;
      check_word("bit clock low phase", {31'h0, pol}, {31'h0, sck});
    end
  endtask : check_clock

  initial
  begin
    {reset_n, hsel, hwrite, listen, m_pol, m_stb_pol} = '0;
    {haddr, hwdata, htrans, n_mismatch, n_compared} = '0;
    hsize = 3'b010;
    repeat (10) @(posedge clk);
    check_word("drive enables", 32'h0, {28'h0, a_oe, b_oe, sck_oe, stb_oe});
    reset_n <= 1'b1;
    rd_chk("ctrl", serial_port_pkg::CTRL_ADDR, 32'h0);
    rd_chk("rate", serial_port_pkg::RATE_ADDR, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr(serial_port_pkg::RATE_ADDR, 32'h1);
    wr(serial_port_pkg::CTRL_ADDR, 32'h1);
    repeat (30) @(posedge clk);
    check_word("drive enables", 32'hF, {28'h0, a_oe, b_oe, sck_oe, stb_oe});
    send_pair(32'h80017FFE, 32'h1234ABCD, 2);
    // Capture stays off while new settings cross into the link domain
    listen = 1'b0;
    m_pol = 1'b1;
    m_stb_pol = 1'b1;
    wr(serial_port_pkg::RATE_ADDR, 32'h0);
    wr(serial_port_pkg::CTRL_ADDR, 32'h0F);
    repeat (30) @(posedge clk);
    check_clock(1'b1);
    send_pair(32'hFFFF0000, 32'h7FFF8000, 1);
    rd_chk("status", serial_port_pkg::STATUS_ADDR, 32'h0);
    listen = 1'b0;
    // Pins must let go again once the enable bit is cleared
    wr(serial_port_pkg::CTRL_ADDR, 32'h0);
    repeat (40) @(posedge clk);
    check_word("drive enables", 32'h0, {28'h0, a_oe, b_oe, sck_oe, stb_oe});
    m_pol = 1'b0;
    m_stb_pol = 1'b0;
    wr(serial_port_pkg::CTRL_ADDR, 32'h11);
    for (int v = 0; v < 8; v++)
    begin
      wr(serial_port_pkg::DEBUG_ADDR, v);
      repeat (20) @(posedge clk);
      check_word("debug lines", v, {29'h0, stb_wire, a_wire, b_wire});
    end
    check_clock(1'b0);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    check_word("drive enables", 32'h0, {28'h0, a_oe, b_oe, sck_oe, stb_oe});
    reset_n <= 1'b1;
    rd_chk("ctrl", serial_port_pkg::CTRL_ADDR, 32'h0);
    rd_chk("debug", serial_port_pkg::DEBUG_ADDR, 32'h0);
    tally_and_finish();
  end
endmodule : tb
